// [verilog/dsc_pkg.sv]
// Notes on behaviour
// - Copy condition codes on debug entry
// - Holding register 0xD8 after special reset
// - Holding register zero in other modes
// - Status access only via debug, unsecured; secured, secure firmware in special mode may write unsecure
// - Enable flag gates activation only
// - Firmware sets enable in special mode; secured waits erase-verify
// - Special mode enable reads zero to host after reset
// - Active set on entry, cleared timed store
// - Active maps firmware table into memory
// - Data-valid set on data, cleared next command
// - Trace set on step, cleared resume
// - Unsecure zero on secure entry; overlay mapped
// - Secured: unsecure writable by secure firmware in special mode
// - Erase pass sets unsecure, drops overlay
// - Unsecure lifts security until next reset or a host status write clears it
// - Unsecure ignored when flash byte unsecured
// - Special mode unsecure reads one when erased
// - Host reaches registers by debug commands
`default_nettype none
package dsc_pkg;
   localparam logic [7:0] HOLD_RST_SPECIAL = 8'hD8;
   localparam logic [7:0] HOLD_RST_OTHER   = 8'h00;
   localparam logic [7:0] STS_RST_SPECIAL  = 8'h40;
   localparam logic [7:0] STS_RST_OTHER    = 8'h00;
   localparam logic [7:0] STS_WMASK        = 8'hDA;
   // Cycles after reset release until both strap flops hold the pin
   localparam logic [1:0] INIT_WAIT        = 2'h2;
   localparam int unsigned BIT_ENABLE  = 7;
   localparam int unsigned BIT_ACTIVE  = 6;
   localparam int unsigned BIT_SDV     = 4;
   localparam int unsigned BIT_TRACE   = 3;
   localparam int unsigned BIT_UNSECURE_FLAG   = 1;
   // Register selects on the debug register port
   localparam logic [1:0] SEL_NONE   = 2'h0;
   localparam logic [1:0] SEL_STATUS = 2'h1;
   localparam logic [1:0] SEL_HOLD   = 2'h2;
endpackage
`default_nettype wire

// [verilog/dsc_hold.sv]
`timescale 1ns/100ps
`default_nettype none
module dsc_hold (
   input  wire logic       clock_i,
   input  wire logic       reset_n_i,
   input  wire logic       init_i,
   input  wire logic       special_i,
   input  wire logic       capture_i,
   input  wire logic [7:0] ccr_i,
   input  wire logic       wr_i,
   input  wire logic [7:0] wdata_i,
   output logic      [7:0] hold_o
);
   typedef struct packed {
      logic [7:0] hold;
   } dsc_hold_s;
   dsc_hold_s state_ff;
   dsc_hold_s nxt_state;

   // Reset load follows the mode strap; capture beats a host write
   always_comb begin
      nxt_state = state_ff;
      if (init_i) begin
         nxt_state.hold = special_i ? dsc_pkg::HOLD_RST_SPECIAL : dsc_pkg::HOLD_RST_OTHER;
      end else if (capture_i) begin
         nxt_state.hold = ccr_i;
      end else if (wr_i) begin
         nxt_state.hold = wdata_i;
      end
   end

   always_ff @(posedge clock_i or negedge reset_n_i) begin
      if (!reset_n_i) begin
         state_ff <= '0;
      end else begin
         state_ff <= nxt_state;
      end
   end

   assign hold_o = state_ff.hold;
endmodule
`default_nettype wire

// [verilog/dsc_top.sv]
`timescale 1ns/100ps
`default_nettype none
module dsc_top (
   input  wire logic       clock_i,
   input  wire logic       reset_n_i,
   input  wire logic       special_mode_i,   // Mode strap, from a pin
   input  wire logic       secured_i,        // Flash security state, from flash block
   input  wire logic       flash_unsecure_i, // Security byte set to unsecured
   input  wire logic [7:0] ccr_i,            // Processor condition codes
   input  wire logic       enter_req_i,      // Core asks to enter debug
   input  wire logic       exit_store_i,     // Firmware timed store clearing active
   input  wire logic       cmd_rx_i,         // Any command received
   input  wire logic       data_done_i,      // Data phase finished
   input  wire logic       step_cmd_i,       // Single-step command recognised
   input  wire logic       resume_cmd_i,     // Resume or resume-until command
   input  wire logic       fw_set_enable_i,  // Firmware setting enable flag
   input  wire logic       erase_ok_i,       // Erase-verify passed
   input  wire logic       erase_done_i,     // Erase-verify complete
   input  wire logic       secure_fw_i,      // Access comes from secure firmware
   input  wire logic       reg_wr_i,         // Debug register write command
   input  wire logic [1:0] reg_sel_i,
   input  wire logic [7:0] reg_wdata_i,
   output logic      [7:0] reg_rdata_o,
   output logic            debug_active_o,
   output logic            fw_table_map_o,
   output logic            secure_table_map_o,
   output logic            security_on_o
);
   typedef struct packed {
      logic       init_done;
      logic [1:0] init_cnt;
      logic [1:0] strap_sync;
      logic       special;
      logic       enable;
      logic       active;
      logic       shift_data_valid;
      logic       trace;
      logic       unsecure_flag;
      logic       sec_map;
      logic [7:0] rdata;
   } dsc_top_s;
   dsc_top_s state_ff;
   dsc_top_s nxt_state;

   logic       init;
   logic       locked;
   logic       st_wr;
   logic       capture;
   logic [7:0] hold;
   logic [7:0] status;

   // Strap passes two flops and is caught three cycles after reset release
   assign init = ~state_ff.init_done;
   assign locked = secured_i & ~flash_unsecure_i & ~state_ff.unsecure_flag;
   assign capture = enter_req_i & state_ff.enable & ~state_ff.active;
   // status write command; security gates bits below
   assign st_wr = reg_wr_i & (reg_sel_i == dsc_pkg::SEL_STATUS);

   always_comb begin
      status = 8'h00;
      status[dsc_pkg::BIT_ENABLE] = state_ff.enable;
      status[dsc_pkg::BIT_ACTIVE] = state_ff.active;
      status[dsc_pkg::BIT_SDV]    = state_ff.shift_data_valid;
      status[dsc_pkg::BIT_TRACE]  = state_ff.trace;
      status[dsc_pkg::BIT_UNSECURE_FLAG]  = state_ff.unsecure_flag;
   end

   // Hardware events win over host writes in the same cycle
   always_comb begin
      nxt_state = state_ff;
      nxt_state.strap_sync = {state_ff.strap_sync[0], special_mode_i};
      if (init) begin
         // Count out the synchroniser; its reset zeros are not the strap
         nxt_state.init_cnt  = state_ff.init_cnt + 2'h1;
         nxt_state.init_done = (state_ff.init_cnt == dsc_pkg::INIT_WAIT);
         nxt_state.special   = state_ff.strap_sync[1];
         nxt_state.active    = state_ff.strap_sync[1];
         nxt_state.enable    = 1'b0;
         nxt_state.shift_data_valid       = 1'b0;
         nxt_state.trace     = 1'b0;
         // cleared on secure entry, overlay mapped
         nxt_state.unsecure_flag     = 1'b0;
         nxt_state.sec_map   = state_ff.strap_sync[1] & secured_i & ~flash_unsecure_i;
      end else begin
         if (st_wr) begin
            // host write only when unsecured; active is hardware owned
            if (!locked) begin
               nxt_state.enable = reg_wdata_i[dsc_pkg::BIT_ENABLE];
               nxt_state.shift_data_valid    = reg_wdata_i[dsc_pkg::BIT_SDV];
               nxt_state.trace  = reg_wdata_i[dsc_pkg::BIT_TRACE];
            end
            // secured writes only from secure firmware
            if (!locked || (state_ff.special && secure_fw_i)) begin
               nxt_state.unsecure_flag = reg_wdata_i[dsc_pkg::BIT_UNSECURE_FLAG];
            end
         end
         if (fw_set_enable_i && state_ff.special && (!locked || erase_done_i)) begin
            nxt_state.enable = 1'b1;
         end
         if (state_ff.sec_map && erase_done_i) begin
            nxt_state.enable = 1'b1;
            if (erase_ok_i) begin
               nxt_state.unsecure_flag   = 1'b1;
               nxt_state.sec_map = 1'b0;
            end
         end
         // active set on entry, cleared by store
         if (exit_store_i) begin
            nxt_state.active = 1'b0;
         end
         if (capture) begin
            nxt_state.active = 1'b1;
         end
         if (cmd_rx_i || exit_store_i) begin
            nxt_state.shift_data_valid = 1'b0;
         end
         if (data_done_i) begin
            nxt_state.shift_data_valid = 1'b1;
         end
         if (resume_cmd_i) begin
            nxt_state.trace = 1'b0;
         end
         if (step_cmd_i) begin
            nxt_state.trace = 1'b1;
         end
      end
      // Registered read data, zero while secured
      case (reg_sel_i)
         dsc_pkg::SEL_STATUS: nxt_state.rdata = locked ? 8'h00 : status;
         dsc_pkg::SEL_HOLD:   nxt_state.rdata = locked ? 8'h00 : hold;
         default:             nxt_state.rdata = 8'h00;
      endcase
   end

   always_ff @(posedge clock_i or negedge reset_n_i) begin
      if (!reset_n_i) begin
         state_ff <= '0;
      end else begin
         state_ff <= nxt_state;
      end
   end

   dsc_hold u_hold (
      .clock_i   (clock_i),
      .reset_n_i (reset_n_i),
      .init_i    (init),
      .special_i (state_ff.strap_sync[1]),
      .capture_i (capture),
      .ccr_i     (ccr_i),
      .wr_i      (reg_wr_i & (reg_sel_i == dsc_pkg::SEL_HOLD) & ~locked),
      .wdata_i   (reg_wdata_i),
      .hold_o    (hold)
   );

   assign reg_rdata_o        = state_ff.rdata;
   assign debug_active_o     = state_ff.active;
   assign fw_table_map_o     = state_ff.active;
   assign secure_table_map_o = state_ff.sec_map;
   assign security_on_o      = locked;
endmodule
`default_nettype wire

// [verification/dsc_props.sv]
`timescale 1ns/100ps
`default_nettype none
// Port-level checks on status flags and register read-back
module dsc_props (
   input wire logic       clock_i,
   input wire logic       reset_n_i,
   input wire logic       special_mode_i,
   input wire logic       secured_i,
   input wire logic       flash_unsecure_i,
   input wire logic [7:0] ccr_i,
   input wire logic       enter_req_i,
   input wire logic       exit_store_i,
   input wire logic       step_cmd_i,
   input wire logic [1:0] reg_sel_i,
   input wire logic [7:0] reg_rdata_o,
   input wire logic       debug_active_o,
   input wire logic       security_on_o
);
   logic [2:0] up_ff;
   wire logic  ok = (up_ff == 3'h7);
   // Masks the strap synchroniser and init, which move flags on their own
   always_ff @(posedge clock_i or negedge reset_n_i)
      if (!reset_n_i)
         up_ff <= 3'h0;
      else if (!ok)
         up_ff <= up_ff + 3'h1;
   default clocking cb @(posedge clock_i); endclocking
   default disable iff (!reset_n_i);
   a_active_cause: assert property (ok && $rose(debug_active_o) |-> $past(enter_req_i))
      else $error("active set without entry");
   a_active_exit: assert property (ok && $fell(debug_active_o) |-> $past(exit_store_i))
      else $error("active cleared without exit store");
   a_read_locked: assert property (security_on_o |=> reg_rdata_o == 8'h00)
      else $error("read data while secured");
   a_zero_bits: assert property
      (ok && $past(reg_sel_i) == dsc_pkg::SEL_STATUS |-> (reg_rdata_o & 8'h25) == 8'h00)
      else $error("reserved status bit set");
   a_capture_ccr: assert property (ok && enter_req_i && !debug_active_o
      && reg_sel_i == dsc_pkg::SEL_HOLD && !secured_i ##1 debug_active_o
      && reg_sel_i == dsc_pkg::SEL_HOLD && !secured_i |=> reg_rdata_o == $past(ccr_i, 2))
      else $error("holding register missed condition codes");
   a_trace_set: assert property (ok && step_cmd_i && !secured_i
      && reg_sel_i == dsc_pkg::SEL_STATUS ##1 reg_sel_i == dsc_pkg::SEL_STATUS && !secured_i
      |=> reg_rdata_o[3]) else $error("trace not set by step");
   a_flash_unsecure_flag: assert property (flash_unsecure_i |-> !security_on_o)
      else $error("security on with unsecured flash byte");
   a_unsecure_flag_guard: assert property (ok && secured_i && !flash_unsecure_i && security_on_o
      && !special_mode_i ##1 secured_i && !flash_unsecure_i |-> security_on_o)
      else $error("security lifted outside special mode");
endmodule
bind dsc_top dsc_props chk_u (.clock_i, .reset_n_i, .special_mode_i, .secured_i,
   .flash_unsecure_i, .ccr_i, .enter_req_i, .exit_store_i, .step_cmd_i, .reg_sel_i,
   .reg_rdata_o, .debug_active_o, .security_on_o);
`default_nettype wire

// [verification/dsc_host.sv]
`timescale 1ns/100ps
`default_nettype none
// Debug host reduced to register write and read commands
module dsc_host (
   input  wire logic       clock_i,
   output logic            reg_wr_o,
   output logic [1:0]      reg_sel_o,
   output logic [7:0]      reg_wdata_o,
   output logic            rd_stb_o
);
   initial {reg_wr_o, reg_sel_o, reg_wdata_o, rd_stb_o} = '0;
   task automatic wr(input logic [1:0] s, input logic [7:0] d);
      {reg_wr_o, reg_sel_o, reg_wdata_o} = {1'b1, s, d};
      @(negedge clock_i);
      {reg_wr_o, reg_wdata_o} = {1'b0, ~d};
      @(negedge clock_i);
   endtask
   // Select held so registered read data settles before the strobe
   task automatic rd(input logic [1:0] s);
      reg_sel_o = s;
      @(negedge clock_i);
      rd_stb_o = 1'b1;
      @(negedge clock_i);
      rd_stb_o = 1'b0;
   endtask
endmodule
`default_nettype wire

// [verification/debug_status_control_tb.sv]
`timescale 1ns/100ps
`default_nettype none
module debug_status_control_tb;
   localparam logic [1:0] ST = dsc_pkg::SEL_STATUS;
   localparam logic [1:0] HD = dsc_pkg::SEL_HOLD;
   logic        clock_i = 1'b0;
   logic        reset_n_i = 1'b0;
   logic        special_mode_i = 1'b0;
   logic        secured_i = 1'b0;
   logic        flash_unsecure_i = 1'b0;
   logic        secure_fw_i = 1'b0;
   logic        erase_ok_i = 1'b0;
   logic [7:0]  ccr_i = 8'h00;
   logic [7:0]  p = 8'h00;
   logic        reg_wr_i, rd_stb, act, map, smap, sec;
   logic [1:0]  reg_sel_i;
   logic [7:0]  reg_wdata_i, reg_rdata_o, d;
   logic [7:0]  exq[$];
   logic [31:0] rs = 32'hf0a7_8b7c;
   int          fail_count = 0;
   int          n_compared = 0;
   dsc_host host_u (.clock_i, .reg_wr_o(reg_wr_i), .reg_sel_o(reg_sel_i),
      .reg_wdata_o(reg_wdata_i), .rd_stb_o(rd_stb));
   dsc_top dut_u (.clock_i, .reset_n_i, .special_mode_i, .secured_i, .flash_unsecure_i,
      .ccr_i, .enter_req_i(p[0]), .exit_store_i(p[1]), .cmd_rx_i(p[2]), .data_done_i(p[3]),
      .step_cmd_i(p[4]), .resume_cmd_i(p[5]), .fw_set_enable_i(p[6]), .erase_ok_i,
      .erase_done_i(p[7]), .secure_fw_i, .reg_wr_i, .reg_sel_i, .reg_wdata_i, .reg_rdata_o,
      .debug_active_o(act), .fw_table_map_o(map), .secure_table_map_o(smap),
      .security_on_o(sec));
   initial forever #5 clock_i = ~clock_i;
   // Xorshift step for random stimulus
   function automatic logic [31:0] xs(input logic [31:0] v);
      logic [31:0] r;
      r = v ^ (v << 13);
      r = r ^ (r >> 17);
      return r ^ (r << 5);
   endfunction
   task automatic check(input logic [7:0] seen, input logic [7:0] exp);
      n_compared++;
      if (seen !== exp) begin
         fail_count++;
         $display("mismatch at %0t: saw %h expected %h", $time, seen, exp);
      end
   endtask
   task automatic test_done;
      $display("compared %0d, mismatches %0d", n_compared, fail_count);
      if (fail_count == 0 && n_compared > 0)
         $display("ALL TESTS PASSED");
      else
         $display("TESTS FAILED");
      $finish;
   endtask
   // Expectation noted first, read issued after
   task automatic rd(input logic [1:0] s, input logic [7:0] e);
      exq.push_back(e);
      host_u.rd(s);
   endtask
   task automatic pulse(input int i);
      p[i] = 1'b1;
      @(negedge clock_i);
      p = 8'h00;
      @(negedge clock_i);
   endtask
   task automatic rst(input logic sp, input logic sc);
      reset_n_i = 1'b0;
      {special_mode_i, secured_i, flash_unsecure_i, erase_ok_i, secure_fw_i} = {sp, sc, 3'h0};
      repeat (8) @(negedge clock_i);
      reset_n_i = 1'b1;
      repeat (6) @(negedge clock_i);
   endtask
   // Monitor pairs each read strobe with the oldest expectation, off the launch edge
   always @(posedge clock_i) begin
      if (rd_stb === 1'b1) begin
         #2;
         check(reg_rdata_o, exq.pop_front());
      end
   end
   // Hang guard
   initial begin
      repeat (20000) @(posedge clock_i);
      fail_count++;
      test_done;
   end
   initial begin
      @(negedge clock_i);
      rst(1'b0, 1'b0);
      rd(HD, 8'h00);
      rd(2'h0, 8'h00);
      pulse(0);
      rd(ST, 8'h00);
      host_u.wr(ST, 8'hFF);
      rd(ST, 8'h9A);
      host_u.wr(ST, 8'h80);
      // Random condition codes and holding values per entry and exit
      repeat (4) begin
         rs = xs(rs);
         {d, ccr_i} = rs[15:0];
         host_u.wr(HD, d);
         rd(HD, d);
         pulse(0);
         check({6'h00, act, map}, 8'h03);
         rd(HD, rs[7:0]);
         pulse(3);
         rd(ST, 8'hD0);
         pulse(4);
         rd(ST, 8'hD8);
         pulse(2);
         pulse(5);
         rd(ST, 8'hC0);
         pulse(3);
         pulse(1);
         rd(ST, 8'h80);
         check(8'(map), 8'h00);
      end
      rst(1'b1, 1'b0);
      rd(HD, 8'hD8);
      pulse(6);
      rd(ST, 8'hC0);
      rst(1'b1, 1'b1);
      rd(ST, 8'h00);
      host_u.wr(ST, 8'h02);
      pulse(7);
      check({6'h00, smap, sec}, 8'h03);
      erase_ok_i = 1'b1;
      pulse(7);
      check({6'h00, smap, sec}, 8'h00);
      rd(ST, 8'hC2);
      rst(1'b1, 1'b1);
      check(8'(sec), 8'h01);
      secure_fw_i = 1'b1;
      host_u.wr(ST, 8'h02);
      check(8'(sec), 8'h00);
      rst(1'b0, 1'b1);
      secure_fw_i = 1'b1;
      host_u.wr(ST, 8'h02);
      check(8'(sec), 8'h01);
      flash_unsecure_i = 1'b1;
      @(negedge clock_i);
      check(8'(sec), 8'h00);
      test_done;
   end
endmodule
`default_nettype wire
